// [rtl/vtes_map.vh]
// Purpose: Offsets, field positions, masks and reset values for the VLAN entry staging block
// Assumes: 32-bit APB, byte addresses, word aligned
// Notes:   Definitions only
`ifndef VTES_MAP_VH
`define VTES_MAP_VH

// Register byte offsets
`define VTES_OFF_ENTRY0    12'h0400
`define VTES_OFF_ENTRY1    12'h0404
`define VTES_OFF_ENTRY2    12'h0408
`define VTES_OFF_INDEX     12'h040C
`define VTES_OFF_ACCESS    12'h0410
`define VTES_OFF_ROUTE     12'h0414

// Word zero fields
`define VTES_VALID_BIT     31
`define VTES_FWDOPT_BIT    27
`define VTES_PRIO_HI       26
`define VTES_PRIO_LO       24
`define VTES_MSTP_HI       14
`define VTES_MSTP_LO       12
`define VTES_FILT_HI       6
`define VTES_FILT_LO       0

// Writable masks, reserved bits read zero
`define VTES_MASK_ENTRY0   32'h8F00_707F
`define VTES_MASK_PORTS    32'h0000_0007
`define VTES_MASK_INDEX    32'h0000_0FFF

// Access control fields
`define VTES_START_BIT     7
`define VTES_ACT_HI        1
`define VTES_ACT_LO        0
`define VTES_ACT_NOP       2'b00
`define VTES_ACT_WRITE     2'b01
`define VTES_ACT_READ      2'b10
`define VTES_ACT_CLEAR     2'b11

// Table geometry and reset values
`define VTES_IDX_W         12
`define VTES_ENTRY_W       21
`define VTES_DEPTH         4096
`define VTES_RST_WORD      32'h0000_0000

`endif

// [rtl/vtes_staging.v]
// Purpose: VLAN table entry staging registers with indirect table access over APB
// Assumes: 20 MHz clk, synchronous active high rst, zero wait state APB slave
// Notes:   Table memory has no reset; software runs the clear action first
`include "vtes_map.vh"
`timescale 1ns/1ns
`default_nettype none

module vtes_staging (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Active entry towards the forwarding logic
  output reg         entry_valid,
  output reg  [2:0]  entry_priority,
  output reg  [2:0]  entry_mstp_index,
  output reg  [6:0]  filter_identifier,
  output reg  [2:0]  entry_untag_ports,
  output reg         forward_option_flag,
  output reg  [2:0]  entry_forward_ports,
  output reg         use_entry_port_map,
  output reg         busy
);

  // Sequencer states
  localparam ST_IDLE  = 2'b00;
  localparam ST_RUN   = 2'b01;
  localparam ST_CLEAR = 2'b10;

  // Packs staging words into one table entry, most significant first:
  // valid, option, priority, instance, filter id, untag bits, forward bits.
  // The entry width must cover all of them or the valid flag is lost.
  function [`VTES_ENTRY_W-1:0] pack_entry;
    input [31:0] w0;
    input [2:0]  w1;
    input [2:0]  w2;
    begin
      pack_entry = {w0[31], w0[27], w0[26:24], w0[14:12], w0[6:0], w1, w2};
    end
  endfunction

  // Table storage, one packed entry per index
  reg [`VTES_ENTRY_W-1:0] table_mem [0:`VTES_DEPTH-1];

  // Staging and control registers
  reg [31:0]              word0_reg;     // Valid, option, priority, instance, filter id
  reg [2:0]               untag_reg;     // Per-port untag bits
  reg [2:0]               fwd_reg;       // Per-port forward bits
  reg [`VTES_IDX_W-1:0]   index_reg;     // Selected entry
  reg [1:0]               action_reg;    // Selected operation
  reg                     start_reg;     // Self-clearing start
  reg [1:0]               state_reg;     // Sequencer state
  reg [`VTES_IDX_W-1:0]   clr_cnt_reg;   // Clear-all walk pointer
  reg [`VTES_ENTRY_W-1:0] rd_entry_reg;  // Entry fetched from the table

  // Bus decode strobes
  wire       acc    = psel & penable;
  wire       wr_acc = acc & pwrite;
  wire [2:0] route_next;

  // Read result select for the forwarding route
  // Effective forward ports as seen through the option flag
  assign route_next = forward_option_flag ? fwd_reg : 3'b000;

  // Table port: one write per cycle, synchronous read
  always @(posedge clk) begin
    if (state_reg == ST_CLEAR) begin
      table_mem[clr_cnt_reg] <= {`VTES_ENTRY_W{1'b0}};
    end else if (state_reg == ST_RUN && action_reg == `VTES_ACT_WRITE) begin
      table_mem[index_reg] <= pack_entry(word0_reg, untag_reg, fwd_reg);
    end
    rd_entry_reg <= table_mem[index_reg];
  end

  // Register writes, sequencer and staging loads
  always @(posedge clk) begin
    if (rst) begin
      word0_reg   <= `VTES_RST_WORD;
      untag_reg   <= 3'b000;
      fwd_reg     <= 3'b000;
      index_reg   <= {`VTES_IDX_W{1'b0}};
      action_reg  <= `VTES_ACT_NOP;
      start_reg   <= 1'b0;
      state_reg   <= ST_IDLE;
      clr_cnt_reg <= {`VTES_IDX_W{1'b0}};
    end else begin
      // Software writes; staging is frozen while an operation runs
      // Writes that land while an operation runs are dropped without an error
      if (wr_acc && !start_reg) begin
        if (paddr == `VTES_OFF_ENTRY0) begin
          word0_reg <= pwdata & `VTES_MASK_ENTRY0;
        end else if (paddr == `VTES_OFF_ENTRY1) begin
          untag_reg <= pwdata[2:0];
        end else if (paddr == `VTES_OFF_ENTRY2) begin
          fwd_reg <= pwdata[2:0];
        end else if (paddr == `VTES_OFF_INDEX) begin
          index_reg <= pwdata[`VTES_IDX_W-1:0];
        end else if (paddr == `VTES_OFF_ACCESS) begin
          action_reg <= pwdata[`VTES_ACT_HI:`VTES_ACT_LO];
          start_reg  <= pwdata[`VTES_START_BIT];
        end
      end
      // Operation sequencer
      case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            if (action_reg == `VTES_ACT_CLEAR) begin
              clr_cnt_reg <= {`VTES_IDX_W{1'b0}};
              state_reg   <= ST_CLEAR;
            end else begin
              state_reg <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          // Read loads every staging word from the fetched entry
          if (action_reg == `VTES_ACT_READ) begin
            // Fields land back at their staging positions; reserved bits stay zero
            word0_reg <= {rd_entry_reg[20], 3'b000, rd_entry_reg[19], rd_entry_reg[18:16],
                          9'h000, rd_entry_reg[15:13], 5'h00, rd_entry_reg[12:6]};
            untag_reg <= rd_entry_reg[5:3];
            fwd_reg   <= rd_entry_reg[2:0];
          end
          start_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        ST_CLEAR: begin
          // Walks every index once; start drops after the last one
          if (clr_cnt_reg == {`VTES_IDX_W{1'b1}}) begin
            start_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            clr_cnt_reg <= clr_cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // APB answer: zero wait states, error on unmapped address
  // The answer is decoded in the setup cycle and stands for the access cycle only
  always @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == `VTES_OFF_ENTRY0) begin
          prdata <= word0_reg;
        end else if (paddr == `VTES_OFF_ENTRY1) begin
          prdata <= {29'h0000_0000, untag_reg};
        end else if (paddr == `VTES_OFF_ENTRY2) begin
          prdata <= {29'h0000_0000, fwd_reg};
        end else if (paddr == `VTES_OFF_INDEX) begin
          prdata <= {20'h0_0000, index_reg};
        end else if (paddr == `VTES_OFF_ACCESS) begin
          prdata <= {24'h00_0000, start_reg, 5'h00, action_reg};
        end else if (paddr == `VTES_OFF_ROUTE) begin
          prdata <= {28'h000_0000, forward_option_flag, route_next};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Staged entry outputs towards the forwarding logic
  // Every output is a flip-flop so downstream timing sees no decode
  always @(posedge clk) begin
    if (rst) begin
      entry_valid         <= 1'b0;
      entry_priority      <= 3'b000;
      entry_mstp_index    <= 3'b000;
      filter_identifier   <= 7'h00;
      entry_untag_ports   <= 3'b000;
      forward_option_flag <= 1'b0;
      entry_forward_ports <= 3'b000;
      use_entry_port_map  <= 1'b0;
      busy                <= 1'b0;
    end else begin
      entry_valid         <= word0_reg[`VTES_VALID_BIT];
      entry_priority      <= word0_reg[`VTES_PRIO_HI:`VTES_PRIO_LO];
      entry_mstp_index    <= word0_reg[`VTES_MSTP_HI:`VTES_MSTP_LO];
      filter_identifier   <= word0_reg[`VTES_FILT_HI:`VTES_FILT_LO];
      entry_untag_ports   <= untag_reg;
      forward_option_flag <= word0_reg[`VTES_FWDOPT_BIT];
      entry_forward_ports <= word0_reg[`VTES_FWDOPT_BIT] ? fwd_reg : 3'b000;
      use_entry_port_map  <= word0_reg[`VTES_FWDOPT_BIT];
      busy                <= start_reg;
    end
  end

endmodule // vtes_staging

`default_nettype wire

// [tb/vtes_staging_properties.sv]
// Purpose: Port checks for the VLAN entry staging block
// Assumes: Zero wait state APB slave, registered entry outputs
// Notes:   Bound to vtes_staging after the module
`include "vtes_map.vh"
`timescale 1ns/1ns
`default_nettype none
module vtes_props (
  // Clock, reset and APB
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Entry outputs
  input wire logic        entry_valid,
  input wire logic [2:0]  entry_priority,
  input wire logic [2:0]  entry_mstp_index,
  input wire logic [6:0]  filter_identifier,
  input wire logic [2:0]  entry_untag_ports,
  input wire logic        forward_option_flag,
  input wire logic [2:0]  entry_forward_ports,
  input wire logic        use_entry_port_map,
  input wire logic        busy
);
  logic [31:0] wd_q, wd_q2;  // Write data one and two cycles back
  localparam int BUSY_LIMIT = 4200;  // Longest allowed busy stretch, clear-all included
  logic [12:0] busy_cnt;     // Cycles that busy has stood high so far
  // Count busy cycles, saturating so a stuck start cannot wrap
  always_ff @(posedge clk)
    if (rst || !busy) busy_cnt <= '0;
    else if (busy_cnt != '1) busy_cnt <= busy_cnt + 13'h0001;
  // Delay write data to line up with the registered outputs
  always_ff @(posedge clk) {wd_q2, wd_q} <= {wd_q, pwdata};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Setup phase, and a staging write that lands while idle
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr(a); psel && penable && pwrite && paddr == a && !busy; endsequence
  chk_ready_setup: assert property (s_setup |=> pready) else $error("no answer");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("answer held");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("bad error answer");
  chk_map_select: assert property (use_entry_port_map == forward_option_flag)
    else $error("map select wrong");
  chk_fwd_gated: assert property (!forward_option_flag |-> entry_forward_ports == 3'h0)
    else $error("forward bits leak");
  chk_start_clears: assert property (busy |-> busy_cnt < BUSY_LIMIT)
    else $error("start stuck");
  chk_fwd_ports: assert property (s_wr(`VTES_OFF_ENTRY2) |=> ##1
    entry_forward_ports == (forward_option_flag ? wd_q2[2:0] : 3'h0)) else $error("forward bits");
  chk_word0_fields: assert property (s_wr(`VTES_OFF_ENTRY0) |=> ##1
    {entry_valid, forward_option_flag, entry_priority, entry_mstp_index, filter_identifier}
    == {wd_q2[31], wd_q2[27], wd_q2[26:24], wd_q2[14:12], wd_q2[6:0]}) else $error("word zero");
  chk_word1_untag: assert property (s_wr(`VTES_OFF_ENTRY1) |=> ##1
    entry_untag_ports == wd_q2[2:0]) else $error("untag bits");
endmodule // vtes_props
bind vtes_staging vtes_props u_props (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .entry_valid, .entry_priority, .entry_mstp_index,
  .filter_identifier, .entry_untag_ports, .forward_option_flag, .entry_forward_ports,
  .use_entry_port_map, .busy);
`default_nettype wire

// [tb/vtes_staging_tb_top.sv]
// Purpose: Self-checking bench for the VLAN entry staging block
// Assumes: 20 MHz clock, zero wait APB slave
// Notes:   A monitor compares each answer with the oldest note
`include "vtes_map.vh"
`timescale 1ns/1ns
`default_nettype none
module vtes_staging_tb_top;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, seed = 32'h0000_227B, rd, w0, w1, w2;
  logic [33:0] expq[$], ex;  // Notes: {compare data, error, data}
  int          mismatches = 0, num_checks = 0;
  wire  [31:0] prdata;
  wire  [6:0]  filter_identifier;
  wire  [2:0]  entry_priority, entry_mstp_index, entry_untag_ports, entry_forward_ports;
  wire         pready, pslverr, entry_valid, forward_option_flag, use_entry_port_map, busy;
  always #25 clk = ~clk;
  vtes_staging dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .entry_valid, .entry_priority, .entry_mstp_index, .filter_identifier,
    .entry_untag_ports, .forward_option_flag, .entry_forward_ports, .use_entry_port_map, .busy);
  // Xorshift stimulus source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // One APB transfer; the expected answer is noted first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    @(posedge clk);
    expq.push_back(e);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {2'b10, d});
  endtask
  // Write, or read back through the masks, the three staging words
  task automatic words(input logic chk, input logic [31:0] a, b, c);
    logic [31:0] m[3] = '{`VTES_MASK_ENTRY0, `VTES_MASK_PORTS, `VTES_MASK_PORTS};
    logic [31:0] v[3];
    v = '{a, b, c};
    for (int i = 0; i < 3; i++)
      apb(!chk, `VTES_OFF_ENTRY0 + 12'(4 * i), v[i], {chk, 1'b0, v[i] & m[i]});
    if (chk) rdx(`VTES_OFF_ROUTE, {28'h000_0000, a[27], a[27] ? c[2:0] : 3'b000});
  endtask
  // Start a table action, poll until done; a probe write while busy must drop
  task automatic op(input logic [1:0] act, input logic [11:0] idx, input logic probe);
    wr(`VTES_OFF_INDEX, {20'h0_0000, idx});
    wr(`VTES_OFF_ACCESS, {24'h00_0000, 6'h20, act});
    if (probe) wr(`VTES_OFF_INDEX, 32'h0000_0ABC);
    do apb(1'b0, `VTES_OFF_ACCESS, 32'h0, 34'h0); while (rd[7] !== 1'b0);
    rdx(`VTES_OFF_ACCESS, {30'h0, act});
    rdx(`VTES_OFF_INDEX, {20'h0_0000, idx});
  endtask
  // Compare every answer with the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1 && expq.size() > 0) begin
      ex = expq.pop_front();
      num_checks++;
      if (pslverr !== ex[32] || (ex[33] && prdata !== ex[31:0])) begin
        mismatches++;
        $display("[FAIL] %0t: got %h/%b want %h/%b", $time, prdata, pslverr, ex[31:0], ex[32]);
      end
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog
  initial begin
    #3_000_000;
    mismatches++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rdx(`VTES_OFF_ENTRY0 + 12'(4 * i), 32'h0);
    repeat (4) begin
      w0 = xs();
      w1 = xs();
      w2 = xs();
      words(1'b0, w0, w1, w2);
      words(1'b1, w0, w1, w2);
    end
    apb(1'b0, 12'h500, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 12'h3FC, 32'hFFFF_FFFF, {2'b01, 32'h0});
    op(2'b11, 12'h005, 1'b1);
    words(1'b0, w0, w1, w2);
    op(2'b01, 12'hFFF, 1'b0);
    words(1'b0, ~w0, ~w1, ~w2);
    op(2'b01, 12'h000, 1'b0);
    op(2'b00, 12'h000, 1'b0);
    words(1'b1, ~w0, ~w1, ~w2);
    op(2'b10, 12'hFFF, 1'b0);
    words(1'b1, w0, w1, w2);
    op(2'b10, 12'h123, 1'b0);
    words(1'b1, 32'h0, 32'h0, 32'h0);
    wrap_up();
  end
endmodule // vtes_staging_tb_top
`default_nettype wire
